//--- hdl/psc_consts.svh
// Constants of the profile sensor command protocol engine
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH

// Command numbers, host to device
`define PSC_CMD_CONNECT 16'h434E
`define PSC_CMD_DISCONNECT 16'h4443
`define PSC_CMD_ENTER 16'h3132
`define PSC_CMD_EXIT 16'h3133
// Command numbers, device to host
`define PSC_CMD_ACK 16'h4141
`define PSC_CMD_NAK 16'h414E
`define PSC_CMD_ZDATA 16'h5A5A
`define PSC_CMD_XDATA 16'h5858
`define PSC_CMD_ZXDATA 16'h5A58
// Connect user data word that asks for the combined packet
`define PSC_COMBINED_SEL 16'h0001

// Header layout, word index within the 15-word header
`define PSC_HDR_WORDS 9'd15
`define PSC_HDR_START0 9'd0
`define PSC_HDR_START1 9'd1
`define PSC_HDR_CMD 9'd3
`define PSC_HDR_TRANS 9'd7
`define PSC_HDR_STATUS 9'd8
`define PSC_HDR_ENC_HI 9'd9
`define PSC_HDR_ENC_LO 9'd10
`define PSC_HDR_SCAN 9'd12
`define PSC_HDR_TYPE 9'd13
`define PSC_HDR_COUNT 9'd14
`define PSC_START_WORD 16'hFFFF
`define PSC_TYPE_WORD 16'h0010

// Payload sizes and value limits
`define PSC_SEP_WORDS 9'd376
`define PSC_ZX_WORDS 9'd480
`define PSC_HI_POINTS 9'd240
`define PSC_SEP_DIV 16'd10
`define PSC_Z_MAX_SEP 16'd8100
`define PSC_Z_MAX_ZX 16'd61000
`define PSC_X_LIM_ZX 16'sd7000

// Status word bit positions
`define PSC_ST_CONN 0
`define PSC_ST_MODE_LSB 4
`define PSC_ST_ACTIVE 8
`define PSC_ST_WARN 9
`define PSC_ST_TRIG 10
`define PSC_ST_MEM 11
`define PSC_ST_ERR 13

// Menu timeout
`define PSC_MENU_TIMEOUT_MIN 3
`define PSC_CLK_HZ 40000000
`define PSC_MENU_TIMEOUT_CYC (64'd60 * `PSC_MENU_TIMEOUT_MIN * 64'd`PSC_CLK_HZ)

`endif

//--- hdl/psc_pkg.sv
// Types of the profile sensor command protocol engine
package psc_pkg;
   // Mode codes equal the status word mode nibble
   typedef enum logic [3:0] {
      psc_measure = 4'b0001,
      psc_menu = 4'b0010,
      psc_command = 4'b0100,
      psc_error = 4'b1000
   } psc_mode_t;

   typedef enum logic [2:0] {
      psc_idle = 3'b001,
      psc_hdr = 3'b010,
      psc_data = 3'b100
   } psc_seq_t;

   typedef enum logic [3:0] {
      psc_k_reply = 4'b0001,
      psc_k_z = 4'b0010,
      psc_k_x = 4'b0100,
      psc_k_zx = 4'b1000
   } psc_kind_t;
endpackage

//--- hdl/psc_buf.sv
// Small shift buffer with valid and ready on both sides
`timescale 1ns/100ps
module psc_buf #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
) (
   input logic mclk,
   input logic rst_n,
   input logic in_valid,
   input logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input logic out_ready
);
   localparam int CW = $clog2(DEPTH + 1);

   generate
      if (DEPTH < 2 || WIDTH < 1) begin : g_bad
         $error("psc_buf needs DEPTH of at least 2 and WIDTH of at least 1");
      end
   endgenerate

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] ent;
      logic [CW-1:0] cnt;
      logic vld;
      logic rdy;
   } psc_buf_state_t;

   psc_buf_state_t s;
   psc_buf_state_t n;

   ////////////////////////////////////////////////////////////////////////
   // Entry 0 is the output; a pop shifts everything down one place
   always_comb begin
      n = s;
      if (s.vld && out_ready) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            n.ent[i] = s.ent[i+1];
         end
         n.cnt = CW'(s.cnt - 1'b1);
      end
      // Ready is registered, so the slot is free even after a pop
      if (in_valid && s.rdy) begin
         n.ent[n.cnt] = in_data;
         n.cnt = CW'(n.cnt + 1'b1);
      end
      n.vld = (n.cnt != '0);
      n.rdy = (n.cnt < CW'(DEPTH));
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{ent: '0, cnt: '0, vld: 1'b0, rdy: 1'b1};
      end else begin
         s <= n;
      end
   end

   assign in_ready = s.rdy;
   assign out_valid = s.vld;
   assign out_data = s.ent[0];
endmodule

//--- hdl/psc_engine.sv
// Protocol engine: mode control, command replies and profile packets
`timescale 1ns/100ps
`include "psc_consts.svh"
module psc_engine #(
   parameter bit HAS_ENCODER = 1'b1,
   parameter bit HI_RES = 1'b1,
   parameter logic [63:0] MENU_TIMEOUT_CYC = `PSC_MENU_TIMEOUT_CYC,
   parameter logic [15:0] NET_TRIGGER_CODE = 16'h0F01,
   parameter logic [15:0] NET_ACTIVATE_CODE = 16'h0F02,
   parameter int BUF_DEPTH = 2
) (
   input logic mclk,
   input logic rst_n,
   input logic cmd_valid,
   input logic [15:0] cmd_code,
   input logic [15:0] cmd_data,
   output logic cmd_ready,
   input logic profile_ready,
   input logic [15:0] pt_z,
   input logic [15:0] pt_x,
   input logic pt_ok,
   output logic [8:0] pt_index,
   input logic button_pin,
   input logic menu_exit,
   input logic encoder_pin,
   input logic cfg_triggered,
   input logic cfg_mem_present,
   input logic warn_in,
   input logic fault_in,
   output logic net_trigger,
   output logic sensor_active,
   output logic connected,
   output psc_pkg::psc_mode_t mode,
   output logic packet_format_flag,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   output logic tx_last,
   input logic tx_ready
);
   import psc_pkg::*;

   localparam int MW = $clog2(MENU_TIMEOUT_CYC + 64'd1);

   generate
      if (MENU_TIMEOUT_CYC < 64'd1 || BUF_DEPTH < 2) begin : g_bad
         $error("psc_engine needs MENU_TIMEOUT_CYC of 1 or more and BUF_DEPTH of 2 or more");
      end
   endgenerate

   typedef struct packed {
      logic [2:0] btn_sync;
      logic btn_lvl;
      logic [2:0] enc_sync;
      logic enc_lvl;
      psc_mode_t mode;
      logic connected;
      logic format;
      logic active;
      logic [MW-1:0] menu_cnt;
      logic [31:0] enc_cnt;
      logic [15:0] scan;
      logic meas_pend;
      logic [15:0] meas_scan;
      logic reply_pend;
      logic [15:0] reply_code;
      logic [15:0] reply_trans;
      psc_seq_t seq;
      psc_kind_t kind;
      logic [15:0] pkt_scan;
      logic [8:0] widx;
      logic hi_byte;
      logic [7:0] hold;
      logic [8:0] pt_index;
      logic cmd_ready;
      logic net_trigger;
   } psc_state_t;

   psc_state_t s;
   psc_state_t n;

   logic press;
   logic take;
   logic ack;
   logic adv;
   logic meas_ok;
   logic last_word;
   logic [15:0] status;
   logic [15:0] hdr_val;
   logic [15:0] data_val;
   logic [15:0] cur_word;
   logic push_valid;
   logic [8:0] push_data;
   logic buf_ready;
   logic [15:0] z_tenths;
   logic signed [15:0] x_signed;
   logic signed [15:0] x_tenths;

   ////////////////////////////////////////////////////////////////////////
   // Payload length of a packet kind
   function automatic logic [8:0] kind_words(input psc_kind_t k);
      unique case (k)
         psc_k_reply: kind_words = 9'd0;
         psc_k_zx: kind_words = `PSC_ZX_WORDS;
         psc_k_z, psc_k_x: kind_words = `PSC_SEP_WORDS;
      endcase
   endfunction

   // Point behind a payload word; combined packets restart at the X half
   function automatic logic [8:0] point_of(input psc_kind_t k, input logic [8:0] idx);
      if (k == psc_k_zx && idx >= `PSC_HI_POINTS) begin
         point_of = 9'(idx - `PSC_HI_POINTS);
      end else begin
         point_of = idx;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Status word, taken live so a change shows in the very next header
   always_comb begin
      status = 16'h0000;
      status[`PSC_ST_CONN] = s.connected;
      status[`PSC_ST_MODE_LSB +: 4] = s.mode;
      status[`PSC_ST_ACTIVE] = s.active;
      status[`PSC_ST_WARN] = warn_in;
      status[`PSC_ST_TRIG] = cfg_triggered;
      status[`PSC_ST_MEM] = cfg_mem_present;
      status[`PSC_ST_ERR] = fault_in;
   end

   // Header word at the current index
   always_comb begin
      hdr_val = 16'h0000;
      unique case (s.widx)
         `PSC_HDR_START0, `PSC_HDR_START1: hdr_val = `PSC_START_WORD;
         `PSC_HDR_CMD: begin
            unique case (s.kind)
               psc_k_reply: hdr_val = s.reply_code;
               psc_k_z: hdr_val = `PSC_CMD_ZDATA;
               psc_k_x: hdr_val = `PSC_CMD_XDATA;
               psc_k_zx: hdr_val = `PSC_CMD_ZXDATA;
            endcase
         end
         // Only command mode replies echo the command; all else zero
         `PSC_HDR_TRANS: hdr_val = (s.kind == psc_k_reply) ? s.reply_trans : 16'h0000;
         `PSC_HDR_STATUS: hdr_val = status;
         `PSC_HDR_ENC_HI: hdr_val = HAS_ENCODER ? s.enc_cnt[31:16] : 16'h0000;
         `PSC_HDR_ENC_LO: hdr_val = HAS_ENCODER ? s.enc_cnt[15:0] : 16'h0000;
         `PSC_HDR_SCAN: hdr_val = (s.kind == psc_k_reply) ? s.scan : s.pkt_scan;
         `PSC_HDR_TYPE: hdr_val = `PSC_TYPE_WORD;
         `PSC_HDR_COUNT: hdr_val = {7'h00, kind_words(s.kind)};
         default: hdr_val = 16'h0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Payload word from the point source; source gives hundredths of a mm
   always_comb begin
      z_tenths = pt_z / `PSC_SEP_DIV;
      x_signed = pt_x;
      x_tenths = x_signed / $signed(`PSC_SEP_DIV);
      data_val = 16'h0000;
      unique case (s.kind)
         psc_k_reply: data_val = 16'h0000;
         psc_k_z: begin
            if (!(HI_RES && s.widx >= `PSC_HI_POINTS)) begin
               data_val = (z_tenths > `PSC_Z_MAX_SEP) ? `PSC_Z_MAX_SEP : z_tenths;
            end
         end
         psc_k_x: begin
            if (!(HI_RES && s.widx >= `PSC_HI_POINTS)) begin
               data_val = x_tenths;
            end
         end
         psc_k_zx: begin
            if (s.widx < `PSC_HI_POINTS) begin
               data_val = (pt_z > `PSC_Z_MAX_ZX) ? `PSC_Z_MAX_ZX : pt_z;
            end else if (x_signed > `PSC_X_LIM_ZX) begin
               data_val = `PSC_X_LIM_ZX;
            end else if (x_signed < -`PSC_X_LIM_ZX) begin
               data_val = -`PSC_X_LIM_ZX;
            end else begin
               data_val = x_signed;
            end
         end
      endcase
      // Occluded or masked-out points go out as zero in both axes
      if (s.kind != psc_k_reply && !pt_ok) begin
         data_val = 16'h0000;
      end
   end

   // Byte offered to the buffer: low byte first, high byte from hold
   always_comb begin
      cur_word = (s.seq == psc_data) ? data_val : hdr_val;
      if (s.seq == psc_data) begin
         last_word = (s.widx == 9'(kind_words(s.kind) - 9'd1));
      end else begin
         last_word = (s.widx == 9'(`PSC_HDR_WORDS - 9'd1)) && (kind_words(s.kind) == 9'd0);
      end
      push_valid = (s.seq != psc_idle);
      push_data = {last_word & s.hi_byte, s.hi_byte ? s.hold : cur_word[7:0]};
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state of the whole engine
   always_comb begin
      n = s;
      n.net_trigger = 1'b0;
      ack = 1'b0;
      adv = push_valid & buf_ready;
      take = cmd_valid & s.cmd_ready;

      // Pins: three flops, a level counts once stages two and three agree
      n.btn_sync = {s.btn_sync[1:0], button_pin};
      if (s.btn_sync[1] == s.btn_sync[2]) begin
         n.btn_lvl = s.btn_sync[1];
      end
      press = n.btn_lvl & ~s.btn_lvl;
      n.enc_sync = {s.enc_sync[1:0], encoder_pin};
      if (s.enc_sync[1] == s.enc_sync[2]) begin
         n.enc_lvl = s.enc_sync[1];
      end
      if (n.enc_lvl && !s.enc_lvl) begin
         n.enc_cnt = s.enc_cnt + 32'h00000001;
      end

      // Command decode, only taken while the sequencer is idle
      if (take) begin
         if (s.mode != psc_menu) begin
            unique case (cmd_code)
               `PSC_CMD_CONNECT: begin
                  if (!s.connected) begin
                     ack = 1'b1;
                     n.connected = 1'b1;
                     n.format = HI_RES && (cmd_data == `PSC_COMBINED_SEL);
                  end
               end
               `PSC_CMD_DISCONNECT: begin
                  if (s.connected) begin
                     ack = 1'b1;
                     n.connected = 1'b0;
                  end
               end
               `PSC_CMD_ENTER: begin
                  if (s.mode != psc_command) begin
                     ack = 1'b1;
                     n.mode = psc_command;
                  end
               end
               `PSC_CMD_EXIT: begin
                  if (s.mode == psc_command) begin
                     ack = 1'b1;
                     n.mode = psc_measure;
                  end
               end
               NET_TRIGGER_CODE: begin
                  if (s.mode != psc_command) begin
                     ack = 1'b1;
                     n.net_trigger = 1'b1;
                  end
               end
               NET_ACTIVATE_CODE: begin
                  if (s.mode != psc_command) begin
                     ack = 1'b1;
                     n.active = cmd_data[0];
                  end
               end
               default: ack = 1'b0;
            endcase
         end
         n.reply_pend = 1'b1;
         n.reply_code = ack ? `PSC_CMD_ACK : `PSC_CMD_NAK;
         n.reply_trans = (n.mode == psc_command) ? cmd_code : 16'h0000;
      end

      // Menu entry wins over everything; fault moves measure mode to error mode and back
      if (press) begin
         n.mode = psc_menu;
         n.menu_cnt = '0;
      end else if (s.mode == psc_menu) begin
         if (menu_exit || s.menu_cnt == MW'(MENU_TIMEOUT_CYC - 64'd1)) begin
            n.mode = psc_measure;
            n.menu_cnt = '0;
         end else begin
            n.menu_cnt = MW'(s.menu_cnt + 1'b1);
         end
      end else if (n.mode == psc_measure && fault_in) begin
         n.mode = psc_error;
      end else if (n.mode == psc_error && !fault_in) begin
         n.mode = psc_measure;
      end

      meas_ok = n.connected && n.active && (n.mode == psc_measure || n.mode == psc_error);
      if (!meas_ok) begin
         n.meas_pend = 1'b0;
      end

      // Packet sequencer; replies go before measurement data
      unique case (s.seq)
         psc_idle: begin
            n.widx = 9'd0;
            n.hi_byte = 1'b0;
            if (s.reply_pend) begin
               n.reply_pend = 1'b0;
               n.kind = psc_k_reply;
               n.seq = psc_hdr;
            end else if (s.meas_pend && meas_ok) begin
               n.meas_pend = 1'b0;
               n.pkt_scan = s.meas_scan;
               n.kind = s.format ? psc_k_zx : psc_k_z;
               n.seq = psc_hdr;
            end
         end
         psc_hdr, psc_data: begin
            if (adv && !s.hi_byte) begin
               n.hold = cur_word[15:8];
               n.hi_byte = 1'b1;
            end else if (adv) begin
               n.hi_byte = 1'b0;
               if (!last_word && s.seq == psc_hdr && s.widx == 9'(`PSC_HDR_WORDS - 9'd1)) begin
                  n.seq = psc_data;
                  n.widx = 9'd0;
                  n.pt_index = point_of(s.kind, 9'd0);
               end else if (!last_word) begin
                  n.widx = 9'(s.widx + 9'd1);
                  if (s.seq == psc_data) begin
                     n.pt_index = point_of(s.kind, 9'(s.widx + 9'd1));
                  end
               end else if (s.kind == psc_k_z) begin
                  // X packet follows at once, same latched scan number
                  n.kind = psc_k_x;
                  n.seq = psc_hdr;
                  n.widx = 9'd0;
               end else begin
                  n.seq = psc_idle;
               end
            end
         end
      endcase

      // Every profile counts; set wins over the sequencer's clear
      if (profile_ready) begin
         n.scan = s.scan + 16'h0001;
         if (meas_ok) begin
            n.meas_pend = 1'b1;
            n.meas_scan = s.scan;
         end
      end

      n.cmd_ready = (n.seq == psc_idle) && !n.reply_pend;
   end

   // Power-up in measure mode, disconnected, separate packets
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{mode: psc_measure, seq: psc_idle, kind: psc_k_reply,
                active: 1'b1, default: '0};
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output buffer, absorbs a stall of the link without losing a byte
   psc_buf #(
      .WIDTH(9),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_valid(push_valid),
      .in_data(push_data),
      .in_ready(buf_ready),
      .out_valid(tx_valid),
      .out_data({tx_last, tx_byte}),
      .out_ready(tx_ready)
   );

   assign cmd_ready = s.cmd_ready;
   assign pt_index = s.pt_index;
   assign net_trigger = s.net_trigger;
   assign sensor_active = s.active;
   assign connected = s.connected;
   assign mode = s.mode;
   assign packet_format_flag = s.format;
endmodule

//--- verif/psc_checker.sv
// Port checker of the profile sensor protocol engine
`timescale 1ns/100ps
module psc_checker (
   input logic mclk,
   input logic rst_n,
   input logic cmd_valid,
   input logic cmd_ready,
   input logic tx_valid,
   input logic [7:0] tx_byte,
   input logic tx_last,
   input logic tx_ready,
   input psc_pkg::psc_mode_t mode,
   input logic connected,
   input logic button_pin,
   input logic menu_exit
);
   import psc_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic [9:0] nbytes;
   ////////////////////////////////////////////////////////////////
   // Bytes accepted so far in the current packet
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) nbytes <= 10'h000;
      else if (tx_valid && tx_ready) nbytes <= tx_last ? 10'h000 : nbytes + 10'h001;
   end
   ////////////////////////////////////////////////////////////////
   tx_hold_a: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_byte) && $stable(tx_last)) else $error("stalled byte moved");
   pkt_len_a: assert property (tx_valid && tx_ready && tx_last |->
      nbytes inside {10'h01D, 10'h30D, 10'h3DD}) else $error("packet length wrong");
   start_word_a: assert property (tx_valid && tx_ready && nbytes < 10'h004 |->
      tx_byte == 8'hFF) else $error("start word wrong");
   cmd_busy_a: assert property (cmd_valid && cmd_ready |=>
      !cmd_ready [*8]) else $error("command taken during reply");
   mode_hot_a: assert property ($onehot(mode)) else $error("mode not one-hot");
   menu_entry_a: assert property ($rose(button_pin) ##1 button_pin [*6] |->
      mode == psc_menu) else $error("button did not enter menu");
   menu_leave_a: assert property (menu_exit && mode == psc_menu && !button_pin |->
      ##[1:3] mode != psc_menu) else $error("menu exit ignored");
   conn_cause_a: assert property ($changed(connected) |-> !cmd_ready)
      else $error("connection changed without command");
   cmd_mode_a: assert property ($changed(mode) && mode == psc_command |-> !cmd_ready)
      else $error("command mode without command");
endmodule

bind psc_engine psc_checker chk (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
   .tx_ready(tx_ready), .mode(mode), .connected(connected), .button_pin(button_pin),
   .menu_exit(menu_exit));

//--- verif/psc_host_model.sv
// Process controller model: takes the byte stream, rebuilds words
`timescale 1ns/100ps
module psc_host_model (
   input logic mclk,
   input logic tx_valid,
   input logic [7:0] tx_byte,
   input logic tx_last,
   input logic stall,
   output logic tx_ready,
   output logic [15:0] hw [0:1][0:494],
   output int pkts
);
   int nb = 0;
   initial tx_ready = 1'b1;
   initial pkts = 0;
   // Slow reader stalls every other cycle to fill the buffer
   always @(posedge mclk) tx_ready <= #1 stall ? ~tx_ready : 1'b1;
   // Low byte then high byte; two banks so X cannot overwrite Z
   always @(posedge mclk) begin
      if (tx_valid && tx_ready) begin
         if (nb < 990) hw[pkts % 2][nb / 2][8 * (nb % 2) +: 8] = tx_byte;
         if (tx_last) begin
            nb = 0;
            pkts++;
         end else nb++;
      end
   end
endmodule

//--- verif/test_profile_sensor_command_protocol.sv
// Self-checking bench of the profile sensor protocol engine
`timescale 1ns/100ps
module test_profile_sensor_command_protocol;
   import psc_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic [15:0] cmd_code = 16'h0000;
   logic [15:0] cmd_data = 16'h0000;
   logic profile_ready = 1'b0;
   logic button_pin = 1'b0;
   logic menu_exit = 1'b0;
   logic encoder_pin = 1'b0;
   logic [3:0] cfg = 4'h0;
   logic stall = 1'b0;
   logic [15:0] zv = 16'h3039;
   logic cmd_ready, net_trigger, sensor_active, connected, packet_format_flag;
   logic tx_valid, tx_last, tx_ready;
   logic [7:0] tx_byte;
   logic [8:0] pt_index;
   psc_mode_t mode;
   logic [15:0] hw [0:1][0:494];
   int pkts;
   int miscompares = 0;
   int num_checks = 0;
   int k;
   logic [15:0] s;

   psc_engine #(.MENU_TIMEOUT_CYC(64'h00000000000000C8)) uut (.mclk(mclk), .rst_n(rst_n),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .profile_ready(profile_ready), .pt_z(zv), .pt_x(16'hFF06),
      .pt_ok(pt_index != 9'h005), .pt_index(pt_index), .button_pin(button_pin),
      .menu_exit(menu_exit), .encoder_pin(encoder_pin), .cfg_triggered(cfg[0]),
      .cfg_mem_present(cfg[1]), .warn_in(cfg[2]), .fault_in(cfg[3]),
      .net_trigger(net_trigger), .sensor_active(sensor_active), .connected(connected),
      .mode(mode), .packet_format_flag(packet_format_flag), .tx_valid(tx_valid),
      .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready));
   psc_host_model host (.mclk(mclk), .tx_valid(tx_valid), .tx_byte(tx_byte),
      .tx_last(tx_last), .stall(stall), .tx_ready(tx_ready), .hw(hw), .pkts(pkts));
   // Trigger pulses are one cycle wide, so they are counted as they pass
   int trig_seen = 0;
   always @(posedge mclk) if (net_trigger === 1'b1) trig_seen++;

   ////////////////////////////////////////////////////////////////
   // Clock, 25 ns period
   initial forever #12.5 mclk = ~mclk;
   // Watchdog well beyond the expected run
   initial begin
      #1000000;
      miscompares++;
      conclude();
   end
   ////////////////////////////////////////////////////////////////
   // Helpers: all driving happens 1 ns after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] w(input int i);
      return hw[(pkts - 1) % 2][i];
   endfunction
   task automatic upto(input int n);
      int c = 0;
      while (pkts < n && c < 8000) begin
         tick(1);
         c++;
      end
      chk(16'(pkts >= n), 16'h0001);
   endtask
   task automatic prof();
      profile_ready = 1'b1;
      tick(1);
      profile_ready = 1'b0;
   endtask
   // Command held until taken, then its reply header judged
   task automatic cmd(input logic [15:0] c, input logic [15:0] d, input logic [15:0] r);
      int n;
      n = pkts + 1;
      cmd_code = c;
      cmd_data = d;
      cmd_valid = 1'b1;
      do @(posedge mclk); while (cmd_ready !== 1'b1);
      #1 cmd_valid = 1'b0;
      upto(n);
      chk(w(3), r);
      chk(w(0), 16'hFFFF);
      chk(w(13), 16'h0010);
      chk(w(14), 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////////
   // Connect, disconnect and the measure mode command set
   task automatic t_conn();
      cfg = 4'h7;
      cmd(16'h434E, 16'h0000, 16'h4141);
      chk(w(8), 16'h0F11);
      chk(w(7), 16'h0000);
      cmd(16'h434E, 16'h0000, 16'h414E);
      cmd(16'h0001, 16'h0000, 16'h414E);
      cmd(16'h0F02, 16'h0000, 16'h4141);
      chk(16'(sensor_active), 16'h0000);
      chk(w(8) & 16'h0100, 16'h0000);
      cmd(16'h0F02, 16'h0001, 16'h4141);
      chk(16'(sensor_active), 16'h0001);
      cmd(16'h0F01, 16'h0000, 16'h4141);
      chk(16'(trig_seen), 16'h0001);
      cmd(16'h4443, 16'h0000, 16'h4141);
      chk(w(8) & 16'h00F1, 16'h0010);
      cmd(16'h4443, 16'h0000, 16'h414E);
      cmd(16'h434E, 16'h0000, 16'h4141);
   endtask
   // Command mode entry, silence and exit
   task automatic t_mode();
      cmd(16'h3132, 16'h0000, 16'h4141);
      chk(w(7), 16'h3132);
      chk(w(8) & 16'h00F1, 16'h0041);
      cmd(16'h3132, 16'h0000, 16'h414E);
      k = pkts;
      prof();
      tick(100);
      chk(16'(pkts - k), 16'h0000);
      cmd(16'h3133, 16'h0000, 16'h4141);
      chk(w(8) & 16'h00F1, 16'h0011);
      cmd(16'h3133, 16'h0000, 16'h414E);
   endtask
   // Three encoder edges advance the low half by three
   task automatic t_enc();
      s = w(10);
      repeat (3) begin
         encoder_pin = 1'b1;
         tick(6);
         encoder_pin = 1'b0;
         tick(6);
      end
      cmd(16'h434E, 16'h0000, 16'h414E);
      chk(w(10), s + 16'h0003);
   endtask
   // Separate packets under a stalling reader
   task automatic t_sep();
      chk(16'(packet_format_flag), 16'h0000);
      stall = 1'b1;
      k = pkts;
      prof();
      upto(k + 1);
      chk(w(3), 16'h5A5A);
      chk(w(14), 16'h0178);
      chk(w(15), 16'h04D2);
      chk(w(20), 16'h0000);
      chk(w(255), 16'h0000);
      s = w(12);
      upto(k + 2);
      chk(w(3), 16'h5858);
      chk(w(15), 16'hFFE7);
      chk(w(12), s);
      prof();
      upto(k + 3);
      chk(w(12), s + 16'h0001);
      upto(k + 4);
      stall = 1'b0;
   endtask
   // Combined packet with a clipped Z value
   task automatic t_comb();
      cmd(16'h4443, 16'h0000, 16'h4141);
      cmd(16'h434E, 16'h0001, 16'h4141);
      chk(16'(packet_format_flag), 16'h0001);
      zv = 16'hFFFF;
      k = pkts;
      prof();
      upto(k + 1);
      chk(w(3), 16'h5A58);
      chk(w(14), 16'h01E0);
      chk(w(15), 16'hEE48);
      chk(w(255), 16'hFF06);
      chk(w(20), 16'h0000);
      chk(w(260), 16'h0000);
   endtask
   // Menu entry, refusal, timeout and exit item
   task automatic t_menu();
      button_pin = 1'b1;
      tick(10);
      button_pin = 1'b0;
      chk(16'(mode), 16'(psc_menu));
      k = pkts;
      prof();
      tick(40);
      chk(16'(pkts - k), 16'h0000);
      cmd(16'h4443, 16'h0000, 16'h414E);
      tick(60);
      chk(16'(mode), 16'(psc_menu));
      tick(150);
      chk(16'(mode), 16'(psc_measure));
      button_pin = 1'b1;
      tick(10);
      button_pin = 1'b0;
      tick(10);
      menu_exit = 1'b1;
      tick(1);
      menu_exit = 1'b0;
      tick(4);
      chk(16'(mode), 16'(psc_measure));
      // Fault input drives error mode and back
      cfg = 4'hF;
      tick(3);
      chk(16'(mode), 16'(psc_error));
      cfg = 4'h7;
      tick(3);
      chk(16'(mode), 16'(psc_measure));
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Reset for five cycles, then the scenarios in turn
   initial begin
      tick(5);
      rst_n = 1'b1;
      tick(3);
      t_conn();
      t_mode();
      t_enc();
      t_sep();
      t_comb();
      t_menu();
      conclude();
   end
endmodule
